/* File: dacc_consts.svh */
// constants for the converter control block: offsets, fields, resets, timing
`ifndef DACC_CONSTS_SVH
`define DACC_CONSTS_SVH
`define DACC_OFS_CONTROL 4'h0
`define DACC_OFS_CODE 4'h1
`define DACC_IDX_CONTROL 0
`define DACC_IDX_CODE 1
`define DACC_BIT_KEEP_RUN 7
`define DACC_BIT_PIN_BUF 6
`define DACC_BIT_ENABLE 0
`define DACC_CONTROL_MASK 8'hC1
`define DACC_CONTROL_RESET 8'h00
`define DACC_CODE_RESET 8'h00
`define DACC_STARTUP_NS 1000
`define DACC_CLK_PERIOD_NS 10
`define DACC_STARTUP_CYCLES ((`DACC_STARTUP_NS + `DACC_CLK_PERIOD_NS - 1) / `DACC_CLK_PERIOD_NS)
`endif

/* File: dacc_pkg.sv */
// types shared by the converter control block
package dacc_pkg;
    typedef enum logic [1:0] {
        DACC_OFF,
        DACC_WARMUP,
        DACC_RUN,
        DACC_SLEEP
    } dacc_state_t;
    typedef logic [7:0] dacc_byte_t;
endpackage

/* File: dacc_control.sv */
// converter control logic with classic wishbone register slave
//
// Implementation choice: the Wishbone slave port.
`timescale 1ns/100ps
`default_nettype none
`include "dacc_consts.svh"

// Overview of operation
// (R01) keep running in standby when keep_running_in_standby set and clock present
// (R02) without that bit, standby halts conversion, powers down core and buffer
// (R03) leaving standby re-powers core, buffer if enabled; wait start-up first
// (R04) power-down sleep always disables core and output buffer
// (R05) control bit 7 blocks automatic shutdown on standby entry
// (R06) control bit 6 turns on output buffer and drives external pin
// (R07) control bit 0 enables converter; bits 7,6,0 RW reset zero, offset 0x00
// (R08) code register at 0x01 holds 8-bit RW value, reset zero
// (R09) while enabled, each code write starts a conversion
// (R10) while disabled, code writes do nothing; enabling starts a conversion; here such writes still load the code register
// (R11) enabled converter output always offered to comparator and ADC
// (R12) control bits 5 to 1 read zero and ignore writes
module dacc_control #(
    parameter int STARTUP_CYCLES = `DACC_STARTUP_CYCLES
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [3:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    input wire logic standby_i,
    input wire logic powerdown_i,
    input wire logic clk_present_i,
    output logic core_on_o,
    output logic buffer_on_o,
    output logic internal_out_valid_o,
    output dacc_pkg::dacc_byte_t conv_code_o,
    output logic conv_start_o,
    output dacc_pkg::dacc_state_t state_o
);
    import dacc_pkg::*;

    // the warm-up counter is 16 bits wide
    initial begin
        if (STARTUP_CYCLES < 1 || STARTUP_CYCLES > 65535) begin
            $error("STARTUP_CYCLES out of range");
        end
    end

    // (R07) (R08) each register answers at its own offset only
    function automatic logic hit(input logic [3:0] adr, input logic [3:0] ofs);
        hit = (adr == ofs);
    endfunction

    dacc_byte_t control_reg, control_next;
    dacc_byte_t code_reg, code_next;
    logic ack_reg, ack_next;
    logic [31:0] rdata_reg, rdata_next;
    dacc_state_t state_reg, state_next;
    logic [15:0] wait_reg, wait_next;
    logic pending_reg, pending_next;
    logic start_reg, start_next;
    dacc_byte_t conv_reg, conv_next;
    logic core_reg, core_next;
    logic buf_reg, buf_next;

    logic take_req;
    logic wr_fire;
    logic enable_bit;
    logic keep_run;
    logic sleep_off;

    assign take_req = cyc_i && stb_i && !ack_reg;
    // writes land at the edge where the master sees ack high, never earlier
    assign wr_fire = cyc_i && stb_i && we_i && sel_i[0] && ack_reg;
    assign enable_bit = control_reg[`DACC_BIT_ENABLE];
    assign keep_run = control_reg[`DACC_BIT_KEEP_RUN];
    // (R04) power-down always off; (R02) (R05) standby off unless kept running
    // (R01) a missing clock in standby also stops the converter
    assign sleep_off = powerdown_i || (standby_i && !(keep_run && clk_present_i));

    always_comb begin
        control_next = control_reg;
        code_next = code_reg;
        ack_next = 1'b0;
        rdata_next = 32'h0000_0000;
        pending_next = pending_reg;
        // a start clears the request first, so a write in the same cycle still counts
        if (start_reg) begin
            pending_next = 1'b0;
        end
        // (R12) other offsets read as zero
        if (take_req) begin
            ack_next = 1'b1;
            if (hit(adr_i, `DACC_OFS_CONTROL)) begin
                rdata_next = {24'h00_0000, control_reg};
            end else if (hit(adr_i, `DACC_OFS_CODE)) begin
                rdata_next = {24'h00_0000, code_reg};
            end
        end
        if (wr_fire && hit(adr_i, `DACC_OFS_CONTROL)) begin
            // (R07) (R12) only bits 7, 6 and 0 are stored
            control_next = dat_i[7:0] & `DACC_CONTROL_MASK;
            // (R10) enabling starts a conversion
            if (dat_i[`DACC_BIT_ENABLE]) begin
                pending_next = 1'b1;
            end
        end
        if (wr_fire && hit(adr_i, `DACC_OFS_CODE)) begin
            // (R08) code register store
            code_next = dat_i[7:0];
            // (R09) write while enabled starts conversion
            if (enable_bit) begin
                pending_next = 1'b1;
            end
        end
    end

    always_comb begin
        state_next = state_reg;
        wait_next = wait_reg;
        start_next = 1'b0;
        conv_next = conv_reg;
        case (state_reg)
            DACC_OFF: begin
                // (R10) enabling brings the core up
                if (enable_bit && !sleep_off) begin
                    state_next = DACC_WARMUP;
                    wait_next = 16'(STARTUP_CYCLES);
                end
            end
            DACC_WARMUP: begin
                if (!enable_bit) begin
                    state_next = DACC_OFF;
                end else if (sleep_off) begin
                    state_next = DACC_SLEEP;
                    // (R03) hold off conversions until start-up has elapsed
                end else if (wait_reg <= 16'h0001) begin
                    state_next = DACC_RUN;
                end else begin
                    wait_next = wait_reg - 16'h0001;
                end
            end
            DACC_RUN: begin
                if (!enable_bit) begin
                    state_next = DACC_OFF;
                end else if (sleep_off) begin
                    // (R02) halt and power down
                    state_next = DACC_SLEEP;
                    // (R09) (R10) launch the pending conversion
                end else if (pending_reg && !start_reg) begin
                    start_next = 1'b1;
                    conv_next = code_reg;
                end
            end
            DACC_SLEEP: begin
                if (!enable_bit) begin
                    state_next = DACC_OFF;
                end else if (!sleep_off) begin
                    // (R03) re-power and wait start-up before converting
                    state_next = DACC_WARMUP;
                    wait_next = 16'(STARTUP_CYCLES);
                end
            end
            default: begin
                state_next = DACC_OFF;
            end
        endcase
        // (R02) (R04) core powered only while warming up or running
        core_next = (state_next == DACC_WARMUP) || (state_next == DACC_RUN);
        // (R06) (R03) buffer follows core when pin buffer bit set
        buf_next = core_next && control_next[`DACC_BIT_PIN_BUF];
    end

    // register file and bus answer
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            control_reg <= `DACC_CONTROL_RESET;
            code_reg <= `DACC_CODE_RESET;
            ack_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            pending_reg <= 1'b0;
        end else begin
            control_reg <= control_next;
            code_reg <= code_next;
            ack_reg <= ack_next;
            rdata_reg <= rdata_next;
            pending_reg <= pending_next;
        end
    end

    // conversion and power state
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg <= DACC_OFF;
            wait_reg <= 16'h0000;
            start_reg <= 1'b0;
            conv_reg <= `DACC_CODE_RESET;
            core_reg <= 1'b0;
            buf_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            wait_reg <= wait_next;
            start_reg <= start_next;
            conv_reg <= conv_next;
            core_reg <= core_next;
            buf_reg <= buf_next;
        end
    end

    assign dat_o = rdata_reg;
    assign ack_o = ack_reg;
    assign core_on_o = core_reg;
    assign buffer_on_o = buf_reg;
    // (R11) internal path follows core regardless of pin buffer
    assign internal_out_valid_o = core_reg;
    assign conv_code_o = conv_reg;
    assign conv_start_o = start_reg;
    assign state_o = state_reg;
endmodule
`default_nettype wire

/* File: dacc_control_properties.sv */
// assertion checker for the converter control block
`timescale 1ns/100ps
`default_nettype none
`include "dacc_consts.svh"
module dacc_control_properties #(
    parameter int STARTUP_CYCLES = `DACC_STARTUP_CYCLES
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [3:0] adr_i,
    input wire logic [31:0] dat_o,
    input wire logic ack_o,
    input wire logic powerdown_i,
    input wire logic core_on_o,
    input wire logic buffer_on_o,
    input wire logic internal_out_valid_o,
    input wire logic conv_start_o,
    input wire dacc_pkg::dacc_state_t state_o
);
    import dacc_pkg::*;
    int wcnt;
    // cycles spent in warm-up so far
    always_ff @(posedge clk_i) begin
        wcnt <= (rst_i || state_o != DACC_WARMUP) ? 0 : wcnt + 1;
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_ack_pulse: assert property (ack_o |=> !ack_o) else $error("ack held");
    a_ack_answer: assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("no ack");
    a_upper_zero: assert property (ack_o |-> dat_o[31:8] == 24'h0) else $error("upper bits");
    a_unmapped_zero: assert property (ack_o && !we_i && adr_i != `DACC_OFS_CONTROL &&
        adr_i != `DACC_OFS_CODE |-> dat_o == 32'h0) else $error("unmapped read");
    a_internal_core: assert property (internal_out_valid_o == core_on_o &&
        core_on_o == (state_o == DACC_WARMUP || state_o == DACC_RUN)) else $error("internal");
    a_buffer_core: assert property (buffer_on_o |-> core_on_o) else $error("buffer no core");
    a_powerdown_off: assert property (powerdown_i [*3] |-> !core_on_o && !buffer_on_o)
        else $error("on in power-down");
    a_start_pulse: assert property (conv_start_o |-> core_on_o ##1 !conv_start_o)
        else $error("bad start");
    a_warmup_len: assert property ($past(state_o) == DACC_WARMUP && state_o == DACC_RUN
        |-> wcnt == STARTUP_CYCLES) else $error("warm-up length");
endmodule
bind dacc_control dacc_control_properties #(.STARTUP_CYCLES(STARTUP_CYCLES)) u_props (
    .clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .dat_o, .ack_o, .powerdown_i,
    .core_on_o, .buffer_on_o, .internal_out_valid_o, .conv_start_o, .state_o);
`default_nettype wire

/* File: dacc_control_tb.sv */
// self-checking bench for the converter control block
`timescale 1ns/100ps
`default_nettype none
`include "dacc_consts.svh"
module dacc_control_tb;
    import dacc_pkg::*;
    logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0;
    logic standby_i = 0, powerdown_i = 0, clk_present_i = 1;
    logic [3:0] adr_i = 4'h0, sel_i = 4'hF;
    logic [31:0] dat_i = 32'h0, dat_o;
    logic ack_o, core_on_o, buffer_on_o, internal_out_valid_o, conv_start_o;
    dacc_byte_t conv_code_o;
    dacc_state_t state_o;
    logic [32:0] rd_q[$];
    logic [8:0] st_q[$];
    int fails = 0, compares = 0;
    logic [15:0] seed = 16'h7406;
    dacc_control #(.STARTUP_CYCLES(2)) DUT (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i,
        .sel_i, .dat_i, .dat_o, .ack_o, .standby_i, .powerdown_i, .clk_present_i, .core_on_o,
        .buffer_on_o, .internal_out_valid_o, .conv_code_o, .conv_start_o, .state_o);
    initial begin
        forever #5 clk_i = ~clk_i;
    end
    function automatic logic [15:0] lfsr(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction
    task automatic chk(input logic [39:0] seen, input logic [39:0] exp, input string what);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic complete_run();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic wb(input logic we, input logic [3:0] adr, input logic [7:0] d);
        int n;
        @(posedge clk_i);
        cyc_i <= 1;
        stb_i <= 1;
        we_i <= we;
        adr_i <= adr;
        dat_i <= {24'h0, d};
        for (n = 0; n < 20; n++) begin
            @(posedge clk_i);
            if (ack_o === 1'b1) break;
        end
        fails += (n == 20);
        if (n == 20) complete_run();
        cyc_i <= 0;
        stb_i <= 0;
    endtask
    task automatic rd(input logic [3:0] adr, input logic [7:0] exp);
        rd_q.push_back({1'b1, 24'h0, exp});
        wb(0, adr, 8'h00);
    endtask
    task automatic wr_code(input logic starts);
        seed = lfsr(seed);
        if (starts) st_q.push_back({1'b1, seed[7:0]});
        wb(1, `DACC_OFS_CODE, seed[7:0]);
    endtask
    task automatic power(input logic c, input logic b);
        int n;
        for (n = 0; n < 50 && core_on_o !== c; n++) begin
            @(posedge clk_i);
        end
        repeat (4) @(posedge clk_i);
        chk(core_on_o, c, "core_on_o");
        chk(buffer_on_o, b, "buffer_on_o");
        chk(internal_out_valid_o, c, "internal_out_valid_o");
    endtask
    always @(posedge clk_i) begin
        if (ack_o === 1'b1 && we_i === 1'b0) chk({1'b1, dat_o}, rd_q.pop_front(), "read");
        if (conv_start_o === 1'b1) chk({1'b1, conv_code_o}, st_q.pop_front(), "start");
    end
    initial begin
        #200000;
        fails++;
        complete_run();
    end
    initial begin
        repeat (12) @(posedge clk_i);
        rst_i <= 0;
        rd(`DACC_OFS_CONTROL, 8'h00);
        rd(`DACC_OFS_CODE, 8'h00);
        rd(4'h8, 8'h00);
        wr_code(0);
        st_q.push_back({1'b1, seed[7:0]});
        wb(1, `DACC_OFS_CONTROL, 8'hFF);
        rd(`DACC_OFS_CONTROL, 8'hC1);
        power(1, 1);
        $display("test enable done");
        repeat (6) wr_code(1);
        rd(`DACC_OFS_CODE, seed[7:0]);
        standby_i <= 1;
        power(1, 1);
        wr_code(1);
        standby_i <= 0;
        powerdown_i <= 1;
        power(0, 0);
        powerdown_i <= 0;
        power(1, 1);
        $display("test keep running done");
        wb(1, `DACC_OFS_CONTROL, 8'h40);
        wr_code(0);
        st_q.push_back({1'b1, seed[7:0]});
        wb(1, `DACC_OFS_CONTROL, 8'h41);
        power(1, 1);
        standby_i <= 1;
        power(0, 0);
        standby_i <= 0;
        power(1, 1);
        $display("test standby stop done");
        st_q.push_back({1'b1, seed[7:0]});
        wb(1, `DACC_OFS_CONTROL, 8'h01);
        power(1, 0);
        // standby without clock stops even when kept running
        st_q.push_back({1'b1, seed[7:0]});
        wb(1, `DACC_OFS_CONTROL, 8'hC1);
        power(1, 1);
        clk_present_i <= 0;
        standby_i <= 1;
        power(0, 0);
        standby_i <= 0;
        clk_present_i <= 1;
        power(1, 1);
        repeat (6) @(posedge clk_i);
        chk(st_q.size(), 0, "pending starts");
        $display("test internal path and clock loss done");
        complete_run();
    end
endmodule
`default_nettype wire
